// file: sse_defs.vh
`ifndef SSE_DEFS_VH
`define SSE_DEFS_VH

// register indices; byte address is four times the index
`define SSE_IDX_E7      8'h27
`define SSE_IDX_E8      8'h28
`define SSE_IDX_E9      8'h29
`define SSE_IDX_STAT    8'h2D

// reset values of the three entries
`define SSE_RST_E7      16'h4F77
`define SSE_RST_E8      16'h5000
`define SSE_RST_E9      16'h5200

// field positions inside an entry
`define SSE_DIR_BIT     15
`define SSE_TAG_HI      14
`define SSE_TAG_LO      9
`define SSE_WRAP_BIT    8
`define SSE_B_HI        7
`define SSE_B_LO        4
`define SSE_A_HI        3
`define SSE_A_LO        0

// slot codes of the decoder
`define SSE_SLOT_E7     2'h0
`define SSE_SLOT_E8     2'h1
`define SSE_SLOT_E9     2'h2
`define SSE_SLOT_NONE   2'h3

// axi responses
`define SSE_RESP_OKAY   2'h0
`define SSE_RESP_SLVERR 2'h2

`endif

// file: sse_seq.v
`include "sse_defs.vh"

module sse_seq (
	// clock and reset
	input  wire       clock,
	input  wire       rst,
	input  wire       clk_en,
	// conversion side
	input  wire       conv_done,
	input  wire       wrap_now,
	// pointer state
	output reg  [1:0] seq_ptr_q,
	output reg        seq_wrap_q
);

	reg [1:0] seq_ptr_d;

	// next slot: wrap to first, or step; past the last slot we also
	// return to the first, since the later entries live elsewhere
	always @* begin
		seq_ptr_d = seq_ptr_q;
		if (conv_done) begin
			if (wrap_now || seq_ptr_q == `SSE_SLOT_E9) begin
				seq_ptr_d = `SSE_SLOT_E7;
			end else begin
				seq_ptr_d = seq_ptr_q + 2'h1;
			end
		end
	end

	// pointer moves only when a conversion has completed
	always @(posedge clock) begin
		if (rst) begin
			seq_ptr_q  <= `SSE_SLOT_E7;
			seq_wrap_q <= 1'b0;
		end else if (clk_en) begin
			seq_ptr_q  <= seq_ptr_d;
			seq_wrap_q <= conv_done && wrap_now;
		end
	end

endmodule

// file: sse_top.v
// How it works
// - bit 15 of an entry: zero asks for read, one asks for write
// - bits 14..9 hold the entry's own address; host must send it
// - return bit clear: step to next entry after conversion ends; entry nine goes back to first
// - return bit set: go back to first entry after conversion ends
// - bits 7..4 pick converter B channel for the active entry
// - bits 3..0 pick converter A channel for the active entry
// - entry seven resets to 0x4F77, wrapping after itself
// - entries eight and nine reset to 0x5000 and 0x5200
`include "sse_defs.vh"

// bus map, byte addresses (index times four):
//   0x09C entry seven, 0x0A0 entry eight, 0x0A4 entry nine
//   0x0B4 pointer status, read only, pointer in bits 1..0
// anything else answers with a slave error and read data of zero
// clk_en low stalls the bus handshakes as well as the sequencer

module sse_top (
	// clock and reset
	input  wire        clock,
	input  wire        rst,
	input  wire        clk_en,
	// axi write address
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// axi write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// axi write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi read address
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// axi read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// converter side
	input  wire        conv_done,
	output wire [1:0]  seq_ptr_q,
	output wire        seq_wrap_q,
	output reg  [3:0]  converter_b_channel_pick_q,
	output reg  [3:0]  converter_a_channel_pick_q
);

	// map a byte address onto a slot; upper bits must be zero
	function [1:0] slot_of;
		input [11:0] addr;
		begin
			if (addr[1:0] != 2'h0 || addr[11:10] != 2'h0) begin
				slot_of = `SSE_SLOT_NONE;
			end else if (addr[9:2] == `SSE_IDX_E7) begin
				slot_of = `SSE_SLOT_E7;
			end else if (addr[9:2] == `SSE_IDX_E8) begin
				slot_of = `SSE_SLOT_E8;
			end else if (addr[9:2] == `SSE_IDX_E9) begin
				slot_of = `SSE_SLOT_E9;
			end else begin
				slot_of = `SSE_SLOT_NONE;
			end
		end
	endfunction

	// reset value of a slot, which also carries its fixed tag
	function [15:0] rst_of;
		input [1:0] slot;
		begin
			case (slot)
				`SSE_SLOT_E7: rst_of = `SSE_RST_E7;
				`SSE_SLOT_E8: rst_of = `SSE_RST_E8;
				default:      rst_of = `SSE_RST_E9;
			endcase
		end
	endfunction

	// the pointer status word sits at its own aligned address
	function is_stat;
		input [11:0] addr;
		begin
			is_stat = (addr == {2'h0, `SSE_IDX_STAT, 2'h0});
		end
	endfunction

	// entry storage
	reg  [15:0] ent_q [0:2];
	// held write address and data
	reg  [11:0] aw_addr_q;
	reg         aw_held_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;
	reg         w_held_q;
	// held read address
	reg  [11:0] ar_addr_q;
	reg         ar_held_q;
	// decode and write path
	wire [1:0]  wr_slot;
	wire [1:0]  rd_slot;
	wire        wr_fire;
	wire        rd_fire;
	wire [15:0] wr_rst;
	wire        wr_tag_ok;
	wire        wr_dir;
	wire        rd_stat;
	wire        rd_err;
	reg  [1:0]  wr_resp;
	reg  [31:0] rd_word;
	reg  [15:0] act_ent;
	integer     i;

	assign wr_slot   = slot_of(aw_addr_q);
	assign rd_slot   = slot_of(ar_addr_q);
	// a write fires once both halves are held and no answer is pending
	assign wr_fire   = aw_held_q && w_held_q && !s_axi_bvalid;
	assign rd_fire   = ar_held_q && !s_axi_rvalid;
	// host must present the entry's own address to reach it; the reset
	// word carries that address, so no second table is kept
	assign wr_rst    = rst_of(wr_slot);
	assign wr_tag_ok = w_data_q[`SSE_TAG_HI:`SSE_TAG_LO] ==
		wr_rst[`SSE_TAG_HI:`SSE_TAG_LO];
	assign wr_dir    = w_data_q[`SSE_DIR_BIT];
	// the status word is readable; any other unmapped read is refused
	assign rd_stat   = is_stat(ar_addr_q);
	assign rd_err    = (rd_slot == `SSE_SLOT_NONE) && !rd_stat;

	// answer for a write; the tag byte lane is needed for the check
	always @* begin
		if (is_stat(aw_addr_q)) begin
			wr_resp = `SSE_RESP_SLVERR; // pointer status is read-only
		end else if (wr_slot == `SSE_SLOT_NONE) begin
			wr_resp = `SSE_RESP_SLVERR;
		end else if (!w_strb_q[1]) begin
			wr_resp = `SSE_RESP_SLVERR; // tag lane missing
		end else if (!wr_tag_ok) begin
			wr_resp = `SSE_RESP_SLVERR;
		end else begin
			wr_resp = `SSE_RESP_OKAY;
		end
	end

	// read multiplexer; narrow registers sit in the low bits
	// (the word is latched into rdata when rvalid rises)
	always @* begin
		rd_word = 32'h0000_0000;
		if (rd_slot != `SSE_SLOT_NONE) begin
			rd_word[15:0] = ent_q[rd_slot];
		end else if (rd_stat) begin
			rd_word[1:0] = seq_ptr_q;
		end
	end

	// write address channel: hold until the response is taken
	// awready stays low while an answer is pending, so a second write
	// cannot slip in before the master has taken the first response
	always @(posedge clock) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			aw_held_q     <= 1'b0;
			aw_addr_q     <= 12'h000;
		end else if (clk_en) begin
			if (s_axi_awready && s_axi_awvalid) begin
				aw_addr_q     <= s_axi_awaddr;
				aw_held_q     <= 1'b1;
				s_axi_awready <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				aw_held_q     <= 1'b0;
			end else if (!aw_held_q && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
		end
	end

	// write data channel, taken in either order with the address
	// the strobes are kept with the data; lane 1 decides acceptance
	always @(posedge clock) begin
		if (rst) begin
			s_axi_wready <= 1'b0;
			w_held_q     <= 1'b0;
			w_data_q     <= 32'h0000_0000;
			w_strb_q     <= 4'h0;
		end else if (clk_en) begin
			if (s_axi_wready && s_axi_wvalid) begin
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				w_held_q     <= 1'b1;
				s_axi_wready <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				w_held_q     <= 1'b0;
			end else if (!w_held_q && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	// write response, one cycle after both halves are held
	// bresp is fixed when bvalid rises and cannot move under the master
	always @(posedge clock) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SSE_RESP_OKAY;
		end else if (clk_en) begin
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_resp;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// entry update: the select bit always lands, the payload only when
	// it asks for write, so a read request leaves the settings intact
	always @(posedge clock) begin
		if (rst) begin
			for (i = 0; i < 3; i = i + 1) begin
				ent_q[i] <= rst_of(i[1:0]);
			end
		end else if (clk_en && wr_fire &&
			wr_resp == `SSE_RESP_OKAY) begin
			ent_q[wr_slot][`SSE_DIR_BIT] <= wr_dir;
			if (wr_dir) begin
				// write request: return bit always, the channel
				// pair only if byte lane 0 came with it
				ent_q[wr_slot][`SSE_WRAP_BIT] <=
					w_data_q[`SSE_WRAP_BIT];
				if (w_strb_q[0]) begin
					ent_q[wr_slot][7:0] <= w_data_q[7:0];
				end
			end
		end
	end

	// read address and data; one read outstanding at a time
	// rdata is captured when rvalid rises, so a later write cannot
	// disturb data the master has not yet taken
	always @(posedge clock) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			ar_held_q     <= 1'b0;
			ar_addr_q     <= 12'h000;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `SSE_RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arready && s_axi_arvalid) begin
				ar_addr_q     <= s_axi_araddr;
				ar_held_q     <= 1'b1;
				s_axi_arready <= 1'b0;
			end else if (rd_fire) begin
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= rd_err ? `SSE_RESP_SLVERR :
					`SSE_RESP_OKAY;
				ar_held_q     <= 1'b0;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
			end else if (!ar_held_q && !s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// the entry the pointer names drives the sequencer
	// slot three never occurs; fall back rather than index past the array
	always @* begin
		act_ent = ent_q[`SSE_SLOT_E7];
		if (seq_ptr_q != `SSE_SLOT_NONE) begin
			act_ent = ent_q[seq_ptr_q];
		end
	end

	// channel pair of the active entry, re-registered each cycle so a
	// rewrite takes hold for the next conversion; after reset the
	// picks are zero for one edge, then follow entry seven
	always @(posedge clock) begin
		if (rst) begin
			converter_b_channel_pick_q <= 4'h0;
			converter_a_channel_pick_q <= 4'h0;
		end else if (clk_en) begin
			converter_b_channel_pick_q <=
				act_ent[`SSE_B_HI:`SSE_B_LO];
			converter_a_channel_pick_q <=
				act_ent[`SSE_A_HI:`SSE_A_LO];
		end
	end

	// sequence pointer; the return bit of entry seven or eight decides
	// whether a finished conversion steps or goes home; entry nine always goes home
	sse_seq u_seq (
		.clock      (clock),
		.rst        (rst),
		.clk_en     (clk_en),
		.conv_done  (conv_done),
		.wrap_now   (act_ent[`SSE_WRAP_BIT]),
		.seq_ptr_q  (seq_ptr_q),
		.seq_wrap_q (seq_wrap_q)
	);

endmodule

// file: sse_chk_asserts.sv
module sse_chk (
	// clock and reset
	input wire        clock,
	input wire        rst,
	input wire        clk_en,
	// sequencer
	input wire        conv_done,
	input wire [1:0]  seq_ptr_q,
	input wire        seq_wrap_q,
	// bus
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ns;
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// pointer only ever names one of the three entries
	ptr_range_a: assert property (seq_ptr_q != 2'h3)
		else $error("pointer left the three entries");
	// a stalled clock enable freezes the pointer like an idle cycle
	ptr_hold_a: assert property (!(conv_done && clk_en)
		|=> $stable(seq_ptr_q))
		else $error("pointer moved without a finished conversion");
	ptr_step_a: assert property (conv_done && clk_en
		|=> seq_ptr_q == 2'h0 ||
		seq_ptr_q == $past(seq_ptr_q) + 2'h1)
		else $error("pointer neither stepped nor returned");
	wrap_home_a: assert property (seq_wrap_q && $past(clk_en)
		|-> seq_ptr_q == 2'h0 && $past(conv_done))
		else $error("wrap pulse without return to first entry");
	// address ready drops after a handshake; bus answers stay put until the master takes them
	aw_drop_a: assert property (s_axi_awvalid && s_axi_awready
		&& clk_en |=> !s_axi_awready)
		else $error("write address ready stayed high");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	// the address is held one edge, the answer is raised on the next
	r_answer_a: assert property (s_axi_arvalid && s_axi_arready
		&& clk_en |-> ##2 s_axi_rvalid &&
		s_axi_rdata[31:16] == 16'h0000)
		else $error("read answer late or upper half not zero");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
endmodule

bind sse_top sse_chk u_chk (.*);

// file: tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// stimulus; clk_en stays high except for one stall check near the end
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        clk_en = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic        s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic [11:0] s_axi_araddr = 12'h000;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        conv_done = 1'b0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire         s_axi_rvalid, seq_wrap_q;
	wire  [1:0]  s_axi_bresp, s_axi_rresp, seq_ptr_q;
	wire  [31:0] s_axi_rdata;
	wire  [3:0]  converter_b_channel_pick_q, converter_a_channel_pick_q;
	wire  [7:0]  pk = {converter_b_channel_pick_q, converter_a_channel_pick_q};
	// bench state; e mirrors the three entries
	int          err_total = 0;
	int          tests_run = 0;
	integer      seed = 32'h2B73;
	logic [15:0] e [3] = '{16'h4F77, 16'h5000, 16'h5200};
	logic [31:0] d;
	logic [3:0]  s;
	logic [1:0]  r, k, p = 2'h0, np;
	logic        ok;

	sse_top dut (.*);

	initial forever #5 clock = ~clock;

	task automatic print_verdict();
		$display("mismatches %0d comparisons %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk_data(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x) begin
			err_total++;
			$display("CHECK FAILED %0t data %h want %h", $time, g, x);
		end
	endtask

	task automatic chk_resp(input logic [1:0] g, input logic [1:0] x);
		tests_run++;
		if (g !== x) begin
			err_total++;
			$display("CHECK FAILED %0t resp %h want %h", $time, g, x);
		end
	endtask

	// ready is raised at random so the slave must hold its answer
	task automatic axw(input logic [11:0] a, input logic [31:0] w,
		input logic [3:0] b, output logic [1:0] q);
		s_axi_awaddr <= a;
		s_axi_wdata <= w;
		s_axi_wstrb <= b;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				q = s_axi_bresp;
				s_axi_bready <= 1'b0;
				return;
			end
			if ($random(seed) & 1) s_axi_bready <= 1'b1;
		end
		err_total++;
		print_verdict();
	endtask

	task automatic axr(input logic [11:0] a, output logic [31:0] w,
		output logic [1:0] q);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				w = s_axi_rdata;
				q = s_axi_rresp;
				s_axi_rready <= 1'b0;
				return;
			end
			if ($random(seed) & 1) s_axi_rready <= 1'b1;
		end
		err_total++;
		print_verdict();
	endtask

	// entry tag and byte address from the slot number
	function automatic logic [5:0] tg(input logic [1:0] x);
		return 6'h27 + {4'h0, x};
	endfunction
	function automatic logic [11:0] adr(input logic [1:0] x);
		return 12'h09C + {8'h00, x, 2'b00};
	endfunction
	// a read request stores only its direction bit
	function automatic logic [15:0] nxt(input logic [15:0] o,
		input logic [31:0] w, input logic [3:0] b);
		if (!w[15]) return {1'b0, o[14:0]};
		return {1'b1, o[14:9], w[8], b[0] ? w[7:0] : o[7:0]};
	endfunction

	task automatic rd_chk(input logic [1:0] x);
		axr(adr(x), d, r);
		chk_data(d, {16'h0000, e[x]});
		chk_resp(r, 2'h0);
	endtask

	// main sequence: reset values, refusals, random writes, sequencer
	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		for (k = 0; k < 3; k++) rd_chk(k);
		axr(12'h0A8, d, r);
		chk_data(d, 32'h0);
		chk_resp(r, 2'h2);
		axw(12'h0B4, 32'h1, 4'hF, r);
		chk_resp(r, 2'h2);
		repeat (24) begin
			k = 2'($random(seed));
			d = $random(seed);
			s = 4'($random(seed));
			if (d[16]) d[14:9] = tg(k);
			ok = k != 2'h3 && s[1] && d[14:9] == tg(k);
			axw(adr(k), d, s, r);
			chk_resp(r, ok ? 2'h0 : 2'h2);
			if (ok) e[k] = nxt(e[k], d, s);
			if (k != 2'h3) rd_chk(k);
		end
		for (int pass = 0; pass < 3; pass++) begin
			for (k = 0; k < 3; k++) begin
				d = $random(seed);
				d[15:8] = {1'b1, tg(k), d[9]};
				axw(adr(k), d, 4'h3, r);
				chk_resp(r, 2'h0);
				e[k] = d[15:0];
			end
			// entry nine has no successor here, so it also goes home
			repeat (4) begin
				np = (e[p][8] || p == 2'h2) ? 2'h0 : p + 2'h1;
				conv_done <= 1'b1;
				@(posedge clock);
				conv_done <= 1'b0;
				#1;
				chk_data({30'h0, seq_ptr_q}, {30'h0, np});
				chk_data({31'h0, seq_wrap_q}, {31'h0, e[p][8]});
				@(posedge clock);
				#1;
				chk_data({24'h0, pk}, {24'h0, e[np][7:0]});
				p = np;
				// back onto an edge so the next pulse is driven there
				@(posedge clock);
			end
		end
		axr(12'h0B4, d, r);
		chk_data(d, {30'h0, p});
		chk_resp(r, 2'h0);
		// clock enable low: finished conversions must not move the pointer
		clk_en <= 1'b0;
		conv_done <= 1'b1;
		repeat (2) @(posedge clock);
		clk_en <= 1'b1;
		conv_done <= 1'b0;
		@(posedge clock);
		chk_data({30'h0, seq_ptr_q}, {30'h0, p});
		// second reset mid-run: defaults return, pointer goes home
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		e = '{16'h4F77, 16'h5000, 16'h5200};
		p = 2'h0;
		for (k = 0; k < 3; k++) rd_chk(k);
		chk_data({24'h0, pk}, 32'h0000_0077);
		axr(12'h0B4, d, r);
		chk_data(d, {30'h0, p});
		print_verdict();
	end
endmodule
